// ### logic/debug_entry_pkg.sv
// Shared types and constants for the debug request entry block
package debug_entry_pkg;

	// ****************************************
	// Bus transfer encodings
	// ****************************************
	localparam logic [1:0] TRANS_IDLE   = 2'h0;
	localparam logic [1:0] TRANS_BUSY   = 2'h1;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic [1:0] TRANS_SEQ    = 2'h3;

	// ****************************************
	// Core state
	// ****************************************
	typedef enum logic [1:0] {
		ST_RUN,
		ST_DRAIN,
		ST_DEBUG
	} entry_state_e;

	// Execution status reported by the core pipeline
	typedef struct packed {
		logic       instr_done;   // Current instruction completes this cycle
		logic       cp_busy_wait; // Current instruction is busy-waiting on a coprocessor
		logic [1:0] trans;        // Transfer type the core wants to issue
		logic       abort;        // Abort response from the bus
		logic       irq;          // Normal interrupt request
		logic       fiq;          // Fast interrupt request
	} core_status_s;

	// Filtered controls handed back to the core
	typedef struct packed {
		logic [1:0] htrans;       // Transfer type put on the bus
		logic       abort;        // Abort passed to the core
		logic       irq;          // Interrupt passed to the core
		logic       fiq;          // Fast interrupt passed to the core
		logic       cp_abandon;   // Abandon busy-waiting coprocessor access
		logic       prefetch_abt; // Breakpoint turned into prefetch abort
		logic       data_abt;     // Watchpoint turned into data abort
	} core_ctrl_s;

	// Debug requests and events
	typedef struct packed {
		logic ext_req;    // External debug request pin
		logic unit_req;   // Request from on-chip breakpoint unit
		logic breakpoint; // Breakpointed instruction reached execute
		logic watchpoint; // Watchpointed data access
	} debug_events_s;

endpackage

// ### logic/debug_event_latch.sv
// Pending flag for debug requests, set wins over clear
`timescale 1ns/1ns
module debug_event_latch
	import debug_entry_pkg::*;
(
	input  wire logic clock,   // System bus clock
	input  wire logic rst,     // Asynchronous reset, active high
	input  wire logic set_in,  // Request seen
	input  wire logic clr_in,  // Request consumed
	output logic      pend     // Request pending
);

	typedef struct packed {
		logic pend;
	} latch_state_s;

	latch_state_s state_q;
	latch_state_s state_d;

	always_comb begin
		state_d = state_q;
		if (clr_in) begin
			state_d.pend = 1'b0;
		end
		if (set_in) begin
			state_d.pend = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pend = state_q.pend;

endmodule

// ### logic/debug_request_entry.sv
// Debug state entry logic: request handling, acknowledge and bus isolation
`timescale 1ns/1ns

module debug_request_entry
	import debug_entry_pkg::*;
(
	input  wire logic          clock,                   // System bus clock, 20 MHz
	input  wire logic          rst,                     // Asynchronous reset, active high
	input  wire logic          monitor_mode,            // 1 monitor mode, 0 halt mode
	input  wire logic          external_debug_request,  // External debug request pin
	input  wire logic          unit_debug_request,      // Request from breakpoint unit
	input  wire logic          breakpoint_hit,          // Breakpointed instruction at execute
	input  wire logic          watchpoint_hit,          // Watchpointed data access
	input  wire logic          debug_resume,            // Debugger restarts the core
	input  wire core_status_s  core_status,             // Pipeline status from the core
	output logic               debug_entry_acknowledge, // High while in debug state
	output core_ctrl_s         core_ctrl                // Filtered controls to core and bus
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		entry_state_e state;
		logic         ack;
		core_ctrl_s   ctrl;
	} entry_regs_s;

	entry_regs_s   regs_q;
	entry_regs_s   regs_d;
	debug_events_s ev;
	logic          req_pend;
	logic          req_seen;
	logic          enter_now;
	logic          in_debug_next;

	assign ev.ext_req    = external_debug_request;
	assign ev.unit_req   = unit_debug_request;
	assign ev.breakpoint = breakpoint_hit;
	assign ev.watchpoint = watchpoint_hit;

	// Requests only count in halt mode and outside debug state
	assign req_seen = !monitor_mode && (regs_q.state != ST_DEBUG) &&
		(ev.ext_req || ev.unit_req || ev.breakpoint || ev.watchpoint);

	// ****************************************
	// Pending request memory
	// ****************************************
	debug_event_latch u_pend (
		.clock  (clock),
		.rst    (rst),
		.set_in (req_seen && !enter_now), // Request taken this cycle is not kept for later
		.clr_in (enter_now),
		.pend   (req_pend)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		regs_d    = regs_q;
		enter_now = 1'b0;
		regs_d.ctrl.cp_abandon   = 1'b0;
		regs_d.ctrl.prefetch_abt = 1'b0;
		regs_d.ctrl.data_abt     = 1'b0;
		case (regs_q.state)
			ST_RUN, ST_DRAIN: begin
				if ((req_seen || req_pend) && core_status.cp_busy_wait) begin
					regs_d.ctrl.cp_abandon = 1'b1;
					enter_now = 1'b1;
				end else if ((req_seen || req_pend) && core_status.instr_done) begin
					enter_now = 1'b1;
				end else if (req_seen || req_pend) begin
					regs_d.state = ST_DRAIN;
				end
				if (enter_now) begin
					regs_d.state = ST_DEBUG;
					regs_d.ack   = 1'b1;
				end
				if (monitor_mode) begin
					regs_d.ctrl.prefetch_abt = ev.breakpoint;
					regs_d.ctrl.data_abt     = ev.watchpoint;
				end
			end
			ST_DEBUG: begin
				regs_d.ack = 1'b1;
				if (debug_resume) begin
					regs_d.state = ST_RUN;
					regs_d.ack   = 1'b0;
				end
			end
			default: begin
				regs_d.state = ST_RUN;
				regs_d.ack   = 1'b0;
			end
		endcase

		in_debug_next = (regs_d.state == ST_DEBUG);
		if (in_debug_next) begin
			regs_d.ctrl.htrans = TRANS_IDLE;
			regs_d.ctrl.abort  = 1'b0;
			regs_d.ctrl.irq    = 1'b0;
			regs_d.ctrl.fiq    = 1'b0;
		end else begin
			regs_d.ctrl.htrans = core_status.trans;
			regs_d.ctrl.abort  = core_status.abort;
			regs_d.ctrl.irq    = core_status.irq;
			regs_d.ctrl.fiq    = core_status.fiq;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regs_q.state <= ST_RUN;
			regs_q.ack   <= 1'b0;
			regs_q.ctrl  <= '0;
		end else begin
			regs_q <= regs_d;
		end
	end

	assign debug_entry_acknowledge = regs_q.ack;
	assign core_ctrl               = regs_q.ctrl;

endmodule

// ### tb/entry_props.sv
// Assertions on debug request entry ports
`timescale 1ns/1ns
module entry_props
	import debug_entry_pkg::*;
(
	input wire logic         clock,                   // Clock
	input wire logic         rst,                     // Reset
	input wire logic         monitor_mode,            // Mode
	input wire logic         external_debug_request,  // Pin
	input wire logic         unit_debug_request,      // Unit
	input wire logic         breakpoint_hit,          // Bkpt
	input wire logic         watchpoint_hit,          // Wpt
	input wire logic         debug_resume,            // Resume
	input wire core_status_s core_status,             // Status
	input wire logic         debug_entry_acknowledge, // Ack
	input wire core_ctrl_s   core_ctrl                // Ctrl
);
	// ****
	// Debug state checks
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic ack, req;
	assign ack = debug_entry_acknowledge;
	assign req = external_debug_request | unit_debug_request;
	idle_trans_a: assert property (ack |-> core_ctrl.htrans == TRANS_IDLE)
		else $error("bus busy in debug");
	mask_abort_a: assert property (ack |-> !core_ctrl.abort)
		else $error("abort in debug");
	mask_irq_a: assert property (ack |-> !(core_ctrl.irq || core_ctrl.fiq))
		else $error("interrupt in debug");
	entry_done_a: assert property (!ack && !monitor_mode && req && core_status.instr_done |=> ack)
		else $error("no entry");
	no_early_a: assert property (!ack && !core_status.instr_done && !core_status.cp_busy_wait |=> !ack)
		else $error("early entry");
	busy_abandon_a: assert property (!ack && !monitor_mode && req && core_status.cp_busy_wait
		|=> ack && core_ctrl.cp_abandon)
		else $error("no abandon");
	ack_hold_a: assert property (ack && !debug_resume |=> ack)
		else $error("ack dropped");
	ack_drop_a: assert property (ack && debug_resume |=> !ack)
		else $error("ack held");
	monitor_abt_a: assert property (monitor_mode && !ack && (breakpoint_hit || watchpoint_hit)
		|=> core_ctrl.prefetch_abt == $past(breakpoint_hit) && core_ctrl.data_abt == $past(watchpoint_hit))
		else $error("no monitor abort");
	cover property (ack && debug_resume);
	cover property (core_ctrl.cp_abandon);
	cover property (core_ctrl.data_abt);
endmodule
bind debug_request_entry entry_props i_props (.*);

// ### tb/requester_model.sv
// Model of the external debug requester
`timescale 1ns/1ns
module requester_model (
	input  wire logic clock,                   // Clock
	input  wire logic rst,                     // Reset
	input  wire logic start,                   // Raise request
	input  wire logic debug_entry_acknowledge, // Ack
	output logic      external_debug_request   // Pin
);
	logic req_q;
	assign external_debug_request = req_q & !debug_entry_acknowledge;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) req_q <= 1'b0;
		else if (debug_entry_acknowledge) req_q <= 1'b0;
		else if (start) req_q <= 1'b1;
	end
endmodule

// ### tb/testbench.sv
// Testbench for debug request entry
`timescale 1ns/1ns
module testbench;
	import debug_entry_pkg::*;
	logic clock = 0, rst = 1, mon = 0, start = 0, unit = 0, bp = 0, wp = 0, res = 0, ack, ext;
	core_status_s cs = '0;
	core_ctrl_s ctrl;
	int bad_count = 0, n_compared = 0;
	debug_request_entry i_dut (.clock(clock), .rst(rst), .monitor_mode(mon), .external_debug_request(ext),
		.unit_debug_request(unit), .breakpoint_hit(bp), .watchpoint_hit(wp), .debug_resume(res),
		.core_status(cs), .debug_entry_acknowledge(ack), .core_ctrl(ctrl));
	requester_model i_req (.clock(clock), .rst(rst), .start(start), .debug_entry_acknowledge(ack),
		.external_debug_request(ext));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (!ok) begin
			bad_count++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic resume;
		@(posedge clock) res <= 1;
		@(posedge clock) res <= 0;
		@(negedge clock) chk(ack === 0, "ack held after resume");
	endtask
	task automatic t_request;
		@(posedge clock) start <= 1;
		@(posedge clock) start <= 0;
		repeat (3) @(posedge clock);
		@(negedge clock) chk(ack === 0, "entered mid instruction");
		// Done, nonseq, abort and interrupts
		@(posedge clock) cs <= 7'h57;
		@(posedge clock) cs.instr_done <= 0;
		@(negedge clock) chk(ack === 1 && ext === 0, "no entry or pin held");
		repeat (3) @(negedge clock) chk(ack === 1 && ctrl.htrans === TRANS_IDLE && ctrl[5:3] === 3'h0, "leak");
		resume();
		@(negedge clock) chk(ctrl.htrans === TRANS_NONSEQ && ctrl.abort === 1 &&
			ctrl.irq === 1 && ctrl.fiq === 1, "no passthrough");
		@(posedge clock) cs <= '0;
	endtask
	task automatic t_busy;
		@(posedge clock) begin
			start <= 1;
			cs.cp_busy_wait <= 1;
		end
		@(posedge clock) start <= 0;
		@(posedge clock) cs.cp_busy_wait <= 0;
		@(negedge clock) chk(ack === 1 && ctrl.cp_abandon === 1, "busy wait kept");
		@(negedge clock) chk(ctrl.cp_abandon === 0, "abandon not a pulse");
		resume();
	endtask
	task automatic t_unit;
		@(posedge clock) begin
			unit <= 1;
			cs.instr_done <= 1;
		end
		@(posedge clock) begin
			unit <= 0;
			cs.instr_done <= 0;
		end
		@(negedge clock) chk(ack === 1, "unit request ignored");
		resume();
	endtask
	task automatic t_monitor;
		@(posedge clock) begin
			mon <= 1;
			bp <= 1;
			cs.instr_done <= 1;
		end
		@(posedge clock) begin
			bp <= 0;
			wp <= 1;
		end
		@(negedge clock) chk(ctrl.prefetch_abt === 1 && ack === 0, "breakpoint not aborted");
		@(posedge clock) begin
			wp <= 0;
			mon <= 0;
			cs.instr_done <= 0;
		end
		@(negedge clock) chk(ctrl.data_abt === 1 && ack === 0, "watchpoint not aborted");
	endtask
	initial forever #25 clock = ~clock;
	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clock);
		rst <= 0;
		@(negedge clock) chk(ack === 0 && ctrl === '0, "reset state");
		t_request();
		$display("Request test done");
		t_busy();
		$display("Busy wait test done");
		t_unit();
		$display("Unit test done");
		t_monitor();
		$display("Monitor test done");
		print_verdict();
	end
endmodule
